// ==== verilog/aclink_slot_codec.sv ====
`timescale 1ns/1ps
`include "aclink_slot_regs.svh"
// Functional notes
// - Slot 5 out holds a 16-bit line A sample, MSB first.
// - Slot 12 GPIO 0..5 are line A signals in fixed order.
// - Slot 12 GPIO 10..15 are line B signals; GPIO 9:6 reserved.
// - Slot 12 low bits: frame detect B, A, GPIO change; bit 3 reserved.
// - Output slots 3, 4, 6-9, 11 are ignored.
// - Input frame is 16-bit tag slot then twelve 20-bit slots.
// - Slot 0 bit 15 shows readiness after reset settles.
// - Once ready, next 12 tag bits mark valid input slots.
// - Sync sampled on falling edge; first input bit on next rising edge.
// - Input bits launch on rising edges, sampled on falling edges.
// - Input stream MSB first; invalid positions drive zero.
// - Input slot 1: bit 19 zero, bits 18:12 echo register index.
// - Slot 1 bit 9 requests line A, bit 4 line B; bits 1:0 zero.
// - Read data in slot 2 bits 19:4; invalid slot is all zero.
// - Line A receive sample in slot 5, MSB first, zero padded.
// - Receive tags suppressed on converter power-down or link halt.
// - Slot 5 stays active while on-hook.
// - Slot 12 reports line, GPIO and isolation link status.
// - Odd register writes ignored, odd reads return zero.
// - Sample request bits in slot 1 are active low.
module aclink_slot_codec (
	input  wire logic                     I_MCLK,
	input  wire logic                     I_SRST,
	input  wire logic                     I_BIT_CLK,
	input  wire logic                     I_SYNC,
	input  wire logic                     I_SDATA_OUT,
	output logic                          O_SDATA_IN,
	output logic                          O_CMD_VALID,
	output aclink_slot_pkg::cmd_t         O_CMD,
	input  wire logic [15:0]              I_READ_DATA,
	output logic                          O_TX_A_VALID,
	output logic [15:0]                   O_TX_A,
	output logic                          O_TX_B_VALID,
	output logic [15:0]                   O_TX_B,
	output logic [15:0]                   O_GPIO_CTRL,
	input  wire logic [15:0]              I_RX_A,
	input  wire logic [15:0]              I_RX_B,
	input  wire aclink_slot_pkg::status_t I_STATUS,
	input  wire logic                     I_REQ_A,
	input  wire logic                     I_REQ_B,
	input  wire logic                     I_RECEIVE_CONVERTER_POWERDOWN,
	input  wire logic                     I_LINK_HALT_REQUEST,
	output logic                          O_READY
);
	// ---------------------------------------------------------------
	// Readiness counter in the system domain
	// ---------------------------------------------------------------
	localparam int READY_N = `READY_CYCLES;
	logic [15:0] ready_cnt;
	logic        ready;
	logic [15:0] next_ready_cnt;
	assign next_ready_cnt = ready ? ready_cnt : ready_cnt + 16'h0001;

	// Ready rises once the settling count runs out after reset.
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			ready_cnt <= 16'h0000;
			ready     <= 1'b0;
		end else begin
			ready_cnt <= next_ready_cnt;
			ready     <= (ready_cnt >= 16'(READY_N - 1));
		end
	end
	assign O_READY = ready;

	// ---------------------------------------------------------------
	// Crossings into the link domain (levels, two flops each)
	// ---------------------------------------------------------------
	logic [1:0]  ctl_l;
	logic [83:0] word_l;
	logic [17:0] stat_l;
	bit_sync #(.WIDTH(2)) u_ctl (
		.i_clk (I_BIT_CLK),
		.i_d   ({ready, I_SRST}),
		.o_q   (ctl_l)
	);
	bit_sync #(.WIDTH(84)) u_word (
		.i_clk (I_BIT_CLK),
		.i_d   ({I_READ_DATA, I_RX_A, I_RX_B, I_REQ_A, I_REQ_B,
		         I_RECEIVE_CONVERTER_POWERDOWN, I_LINK_HALT_REQUEST, 16'h0000,
		         16'h0000}),
		.o_q   (word_l)
	);
	bit_sync #(.WIDTH(18)) u_stat (
		.i_clk (I_BIT_CLK),
		.i_d   (I_STATUS),
		.o_q   (stat_l)
	);
	logic [83:0] word_p;
	logic [83:0] word_h;

	// A word is taken only after two equal link samples, so a value caught
	// mid-change never reaches a frame; a word that changes every link cycle stalls.
	always_ff @(posedge I_BIT_CLK) begin
		word_p <= word_l;
		if (word_l == word_p)
			word_h <= word_l;
	end
	wire        l_ready = ctl_l[1];
	wire        l_rst   = ctl_l[0];
	wire [15:0] l_rdata = word_h[83:68];
	wire [15:0] l_rx_a  = word_h[67:52];
	wire [15:0] l_rx_b  = word_h[51:36];
	wire        l_req_a = word_h[35];
	wire        l_req_b = word_h[34];
	wire        l_pd    = word_h[33];
	wire        l_halt  = word_h[32];

	// ---------------------------------------------------------------
	// Link-side framing: sync sampled on falling edge
	// ---------------------------------------------------------------
	logic       sync_q;
	logic       active;
	logic [7:0] bit_pos;
	wire        frame_start = I_SYNC && !sync_q;

	// The falling edge that sees sync rise marks frame position zero, which is bit 15 of slot 0.
	always_ff @(negedge I_BIT_CLK) begin
		if (l_rst) begin
			sync_q  <= 1'b0;
			active  <= 1'b0;
			bit_pos <= `FRAME_BITS;
		end else begin
			sync_q  <= I_SYNC;
			// The last frame bit shares the idle position, so a flag keeps it in frame.
			active  <= frame_start || (active && bit_pos != `FRAME_BITS);
			bit_pos <= frame_start ? 8'h00 :
			           (bit_pos == `FRAME_BITS) ? bit_pos : bit_pos + 8'h01;
		end
	end

	// Slot number and bit within slot from the frame position.
	function automatic logic [3:0] slot_of(input logic [7:0] pos);
		slot_of = (pos < 8'(`TAG_BITS)) ? 4'd0 :
		          4'(((pos - 8'(`TAG_BITS)) / 8'(`SLOT_BITS)) + 8'h01);
	endfunction
	function automatic logic [4:0] sbit_of(input logic [7:0] pos);
		sbit_of = (pos < 8'(`TAG_BITS)) ? 5'(8'(`TAG_BITS) - 8'h01 - pos) :
		          5'(8'(`SLOT_BITS) - 8'h01 - ((pos - 8'(`TAG_BITS)) % 8'(`SLOT_BITS)));
	endfunction

	// ---------------------------------------------------------------
	// Output-frame decode (falling-edge capture)
	// ---------------------------------------------------------------
	logic [15:0] tag_in;
	logic [19:0] shreg;
	logic [19:0] slot1_in;
	logic        last_rd;
	logic [6:0]  last_idx;
	logic        cmd_tgl;
	logic        txa_tgl;
	logic        txb_tgl;
	logic        gpio_tgl;
	logic [15:0] cap_data;
	logic [15:0] cap_a;
	logic [15:0] cap_b;
	logic [15:0] cap_gpio;
	wire  [3:0]  cur_slot = slot_of(bit_pos);
	wire  [4:0]  cur_bit  = sbit_of(bit_pos);
	wire         in_frame = active;
	wire         frame_first = active && bit_pos == 8'h00;
	wire  [19:0] full_w   = {shreg[18:0], I_SDATA_OUT};
	wire         slot_end = in_frame && cur_slot != 4'd0 && cur_bit == 5'd0;
	wire         frame_ok = tag_in[15];
	wire         cmd_hit  = frame_ok && tag_in[`TAG_S1];

	// Shift in MSB first; latch slots 0, 1, 2, 5, 10 and 12 at their last bit.
	always_ff @(negedge I_BIT_CLK) begin
		if (l_rst) begin
			tag_in <= 16'h0000; shreg <= 20'h00000; slot1_in <= 20'h00000;
			last_rd <= 1'b0; last_idx <= 7'h00;
			cmd_tgl <= 1'b0; txa_tgl <= 1'b0; txb_tgl <= 1'b0;
			gpio_tgl <= 1'b0;
			cap_data <= 16'h0000; cap_a <= 16'h0000; cap_b <= 16'h0000;
			cap_gpio <= 16'h0000;
		end else if (in_frame) begin
			shreg <= full_w;
			if (cur_slot == 4'd0 && cur_bit == 5'd0)
				tag_in <= full_w[15:0];
			if (slot_end && cur_slot == `SLOT_CMD_ADDR)
				slot1_in <= full_w;
			if (slot_end && cur_slot == `SLOT_CMD_DATA && cmd_hit) begin
				last_rd  <= slot1_in[`S1_READ_BIT];
				last_idx <= slot1_in[18:12];
				// Odd-index writes never reach the register file; odd reads still pass.
				if (!slot1_in[12] || slot1_in[`S1_READ_BIT]) begin
					cap_data <= full_w[19:4];
					cmd_tgl  <= ~cmd_tgl;
				end
			end
			if (slot_end && cur_slot == `SLOT_LINE_A && frame_ok && tag_in[`TAG_S5]) begin
				cap_a   <= full_w[19:4];
				txa_tgl <= ~txa_tgl;
			end
			if (slot_end && cur_slot == `SLOT_LINE_B && frame_ok && tag_in[`TAG_S10]) begin
				cap_b   <= full_w[19:4];
				txb_tgl <= ~txb_tgl;
			end
			// Slots 3, 4, 6-9 and 11 are shifted past and never latched.
			if (slot_end && cur_slot == `SLOT_GPIO && frame_ok && tag_in[`TAG_S12]) begin
				cap_gpio <= full_w[19:4] & ~`GPIO_RSVD_MASK;
				gpio_tgl <= ~gpio_tgl;
			end
		end
	end

	// ---------------------------------------------------------------
	// Input-frame build (rising-edge launch)
	// ---------------------------------------------------------------
	wire rx_on   = l_ready && !l_pd && !l_halt;
	wire rd_odd  = last_rd && last_idx[0];
	wire [15:0] tag_out = l_ready ?
	    {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, rx_on, 1'b0, 1'b0, 1'b0, 1'b0, rx_on,
	     1'b0, 1'b1, 3'b000} : 16'h0000;
	wire [19:0] s1_out = {1'b0, last_idx, 2'b00, ~l_req_a, 4'b0000, ~l_req_b,
	                      4'b0000};
	wire [19:0] s2_out = {(last_rd && !rd_odd) ? l_rdata : 16'h0000, 4'h0};
	logic [15:0] gpio_prev;
	logic        gpio_chg;
	wire [19:0] s12_out = {stat_l[17:2] & ~`GPIO_RSVD_MASK, 1'b0, stat_l[1],
	                       stat_l[0], gpio_chg};
	wire  [19:0] slot_word =
	    (cur_slot == `SLOT_CMD_ADDR) ? s1_out :
	    (cur_slot == `SLOT_CMD_DATA) ? s2_out :
	    (cur_slot == `SLOT_LINE_A && rx_on) ? {l_rx_a, 4'h0} :
	    (cur_slot == `SLOT_LINE_B && rx_on) ? {l_rx_b, 4'h0} :
	    (cur_slot == `SLOT_GPIO) ? s12_out : 20'h00000;
	wire next_sdata = !in_frame || !l_ready ? 1'b0 :
	    (cur_slot == 4'd0) ? tag_out[cur_bit[3:0]] : slot_word[cur_bit];

	// Bit launched on the rising edge after its falling-edge position.
	always_ff @(posedge I_BIT_CLK) begin
		if (l_rst) begin
			O_SDATA_IN <= 1'b0;
			gpio_prev  <= 16'h0000;
			gpio_chg   <= 1'b0;
		end else begin
			O_SDATA_IN <= next_sdata;
			if (frame_first) begin
				gpio_prev <= stat_l[17:2];
				gpio_chg  <= gpio_prev != stat_l[17:2];
			end
		end
	end

	// ---------------------------------------------------------------
	// Return to the system domain: toggles for events, flops for words
	// ---------------------------------------------------------------
	logic [3:0] tg_s;
	logic [3:0] tg_d;
	logic [3:0] tg_dd;
	logic [16+16+16+16+8-1:0] w_s;
	bit_sync #(.WIDTH(4)) u_tg (
		.i_clk (I_MCLK),
		.i_d   ({cmd_tgl, txa_tgl, txb_tgl, gpio_tgl}),
		.o_q   (tg_s)
	);
	bit_sync #(.WIDTH(72)) u_w (
		.i_clk (I_MCLK),
		.i_d   ({cap_data, cap_a, cap_b, cap_gpio, last_rd, last_idx}),
		.o_q   (w_s)
	);
	wire [3:0] tg_ev = tg_d ^ tg_dd;

	// A word changes on the same link edge as its toggle, so its own
	// synchroniser may still settle when the toggle lands; the event is
	// acted on one system cycle later, once the word is clean.
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			tg_d <= 4'h0;
			tg_dd <= 4'h0;
			O_CMD_VALID <= 1'b0; O_TX_A_VALID <= 1'b0; O_TX_B_VALID <= 1'b0;
			O_CMD <= '0; O_TX_A <= 16'h0000; O_TX_B <= 16'h0000;
			O_GPIO_CTRL <= 16'h0000;
		end else begin
			tg_d         <= tg_s;
			tg_dd        <= tg_d;
			O_CMD_VALID  <= tg_ev[3];
			O_TX_A_VALID <= tg_ev[2];
			O_TX_B_VALID <= tg_ev[1];
			if (tg_ev[3]) O_CMD <= '{rd: w_s[7], index: w_s[6:0], data: w_s[71:56]};
			if (tg_ev[2]) O_TX_A <= w_s[55:40];
			if (tg_ev[1]) O_TX_B <= w_s[39:24];
			if (tg_ev[0]) O_GPIO_CTRL <= w_s[23:8];
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_frame_begin;
		!sync_q ##1 sync_q;
	endsequence
	sequence s_rx_slot_off;
		(l_pd || l_halt) && in_frame && (cur_slot == `SLOT_LINE_A || cur_slot == `SLOT_LINE_B);
	endsequence
	a_ready_gate: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		!ready |-> ready_cnt < 16'(READY_N)) else $error("ready late");
	a_ready_sticky: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		ready |=> ready) else $error("ready dropped");
	a_sync_start: assert property (@(negedge I_BIT_CLK) disable iff (l_rst)
		s_frame_begin |-> bit_pos == 8'h00) else $error("frame not started");
	a_not_ready_zero: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		!l_ready |=> !O_SDATA_IN) else $error("data before ready");
	a_rx_suppress: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		(l_pd || l_halt) |-> !tag_out[`TAG_S5] && !tag_out[`TAG_S10])
		else $error("rx tag while off");
	a_rx_data_off: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		s_rx_slot_off |=> !O_SDATA_IN) else $error("rx data while off");
	a_s1_msb_zero: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		!s1_out[19] && s1_out[1:0] == 2'b00) else $error("slot1 pad");
	a_req_low: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		l_req_a |-> !s1_out[`S1_REQ_A_BIT]) else $error("req polarity");
	a_odd_read: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		rd_odd |-> s2_out == 20'h00000) else $error("odd read data");
	a_s12_rsvd: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		s12_out[13:10] == 4'h0 && !s12_out[3]) else $error("slot12 reserved");
	a_launch: assert property (@(posedge I_BIT_CLK) disable iff (l_rst)
		frame_first |=> O_SDATA_IN == $past(l_ready)) else $error("launch slip");
endmodule

// ==== verilog/aclink_slot_regs.svh ====
`ifndef ACLINK_SLOT_REGS_SVH
`define ACLINK_SLOT_REGS_SVH
// Frame geometry.
`define TAG_BITS        5'd16
`define SLOT_BITS       5'd20
`define SLOT_COUNT      4'd12
`define FRAME_BITS      8'd255
// Slot 0 positions.
`define TAG_READY       4'd15
`define TAG_S1          4'd14
`define TAG_S2          4'd13
`define TAG_S5          4'd10
`define TAG_S10         4'd5
`define TAG_S12         4'd3
// Slot numbers.
`define SLOT_CMD_ADDR   4'd1
`define SLOT_CMD_DATA   4'd2
`define SLOT_LINE_A     4'd5
`define SLOT_LINE_B     4'd10
`define SLOT_GPIO       4'd12
// Slot 1 fields.
`define S1_READ_BIT     5'd19
`define S1_REQ_A_BIT    5'd9
`define S1_REQ_B_BIT    5'd4
// Slot 12: GPIO position N sits at slot bit N+4.
`define GPIO_SHIFT      5'd4
`define GPIO_RSVD_MASK  16'h03c0
`define VOPT_FDT_B      5'd2
`define VOPT_FDT_A      5'd1
`define VOPT_GPIO_CHG   5'd0
// Readiness settling time after reset.
`define READY_TIME_NS   1000
`define CLK_PERIOD_NS   25
`define READY_CYCLES    ((`READY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== verilog/aclink_slot_pkg.sv ====
package aclink_slot_pkg;
	typedef struct packed {
		logic        rd;
		logic [6:0]  index;
		logic [15:0] data;
	} cmd_t;
	typedef struct packed {
		logic [15:0] gpio;
		logic        fdt_b;
		logic        fdt_a;
	} status_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TAG  = 2'b01,
		ST_DATA = 2'b11
	} phase_t;
endpackage

// ==== verilog/bit_sync.sv ====
`timescale 1ns/1ps
// Two-stage level synchroniser; stage one feeds only stage two.
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta;

	// Resetless so that the crossing never sees a reset-driven mux.
	always_ff @(posedge i_clk) begin
		meta <= i_d;
		o_q  <= meta;
	end
endmodule

// ==== sim/aclink_ctrl_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Controller end of the serial link
// ----------------------------------------
module aclink_ctrl_model (
	input  wire logic i_bit_clk,
	output logic      o_sync,
	output logic      o_sdata_out,
	input  wire logic i_sdata_in
);
	initial begin
		o_sync = 1'b0;
		o_sdata_out = 1'b0;
	end

	// Plays one output frame and gathers the input frame; the caller pads fields with zeros.
	// The frame ends by driving the data line low, since the controller never releases it.
	task automatic run_frame(input logic [255:0] tx, output logic [255:0] rx);
		for (int k = 0; k <= 256; k++) begin
			@(posedge i_bit_clk);
			o_sync <= (k < 16);
			o_sdata_out <= (k >= 1) ? tx[256-k] : 1'b0;
			@(negedge i_bit_clk);
			if (k >= 1) begin
				rx[256-k] = i_sdata_in;
			end
		end
		@(posedge i_bit_clk);
		o_sdata_out <= 1'b0;
	endtask
endmodule

// ==== sim/tb_aclink_slot_codec.sv ====
`timescale 1ns/1ps
module tb_aclink_slot_codec;
	logic                     I_MCLK, I_SRST, I_BIT_CLK, I_SYNC, I_SDATA_OUT, O_SDATA_IN;
	logic                     O_CMD_VALID, O_TX_A_VALID, O_TX_B_VALID, O_READY;
	logic                     I_REQ_A, I_REQ_B, I_RECEIVE_CONVERTER_POWERDOWN, I_LINK_HALT_REQUEST;
	logic [15:0]              I_READ_DATA, O_TX_A, O_TX_B, O_GPIO_CTRL, I_RX_A, I_RX_B;
	aclink_slot_pkg::cmd_t    O_CMD, last_cmd;
	aclink_slot_pkg::status_t I_STATUS;
	logic [255:0]             rx;
	logic [15:0]              last_a, last_b;
	int                       error_cnt, n_tests, cmd_cnt, a_cnt, b_cnt, n0;

	aclink_slot_codec aclink_slot_codec_inst (.I_MCLK(I_MCLK), .I_SRST(I_SRST),
		.I_BIT_CLK(I_BIT_CLK), .I_SYNC(I_SYNC), .I_SDATA_OUT(I_SDATA_OUT),
		.O_SDATA_IN(O_SDATA_IN), .O_CMD_VALID(O_CMD_VALID), .O_CMD(O_CMD),
		.I_READ_DATA(I_READ_DATA), .O_TX_A_VALID(O_TX_A_VALID), .O_TX_A(O_TX_A),
		.O_TX_B_VALID(O_TX_B_VALID), .O_TX_B(O_TX_B), .O_GPIO_CTRL(O_GPIO_CTRL),
		.I_RX_A(I_RX_A), .I_RX_B(I_RX_B), .I_STATUS(I_STATUS), .I_REQ_A(I_REQ_A),
		.I_REQ_B(I_REQ_B), .I_RECEIVE_CONVERTER_POWERDOWN(I_RECEIVE_CONVERTER_POWERDOWN),
		.I_LINK_HALT_REQUEST(I_LINK_HALT_REQUEST), .O_READY(O_READY));
	aclink_ctrl_model aclink_ctrl_model_inst (.i_bit_clk(I_BIT_CLK), .o_sync(I_SYNC),
		.o_sdata_out(I_SDATA_OUT), .i_sdata_in(O_SDATA_IN));

	// ----------------------------------------
	// Clocks, event capture and helpers
	// ----------------------------------------
	// The bit clock is offset so its edges never line up with the system clock.
	initial begin
		I_MCLK = 1'b0;
		forever #12.5 I_MCLK = ~I_MCLK;
	end
	initial begin
		I_BIT_CLK = 1'b0;
		#7;
		forever #15 I_BIT_CLK = ~I_BIT_CLK;
	end
	// Pulses are counted on the falling edge, clear of the edge that launches them.
	always @(negedge I_MCLK) begin
		if (O_CMD_VALID === 1'b1) begin cmd_cnt++; last_cmd = O_CMD; end
		if (O_TX_A_VALID === 1'b1) begin a_cnt++; last_a = O_TX_A; end
		if (O_TX_B_VALID === 1'b1) begin b_cnt++; last_b = O_TX_B; end
	end
	function automatic logic [255:0] frame(input logic [15:0] tag,
		input logic [19:0] s1, s2, s5, s10, s12);
		return {tag, s1, s2, 40'h0, s5, 80'h0, s10, 20'h0, s12};
	endfunction
	function automatic logic [19:0] slot(input int n);
		return rx[239-20*(n-1) -: 20];
	endfunction
	task automatic xfer(input logic [255:0] tx);
		aclink_ctrl_model_inst.run_frame(tx, rx);
		repeat (10) @(negedge I_MCLK);
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_ready();
		repeat (38) @(negedge I_MCLK);
		check(O_READY, 0);
		repeat (4) @(negedge I_MCLK);
		check(O_READY, 1);
		xfer(frame(16'h0000, 0, 0, 0, 0, 0));
		check(rx[255], 1);
		$display("test_ready done");
	endtask
	// A write, then an odd-index write that must leave no trace.
	task automatic test_write();
		n0 = cmd_cnt;
		xfer(frame(16'he000, {1'b0, 7'h10, 12'h0}, {16'h1234, 4'h0}, 0, 0, 0));
		check(cmd_cnt - n0, 1);
		check(last_cmd, {1'b0, 7'h10, 16'h1234});
		check(rx[255:240], 16'he428);
		xfer(frame(16'he000, {1'b0, 7'h11, 12'h0}, {16'hdead, 4'h0}, 0, 0, 0));
		check(cmd_cnt - n0, 1);
		$display("test_write done");
	endtask
	task automatic test_read(input logic [6:0] idx, input logic [15:0] exp);
		@(negedge I_MCLK);
		I_READ_DATA = 16'hbeef;
		xfer(frame(16'hc000, {1'b1, idx, 12'h0}, 0, 0, 0, 0));
		xfer(frame(16'h8000, 0, 0, 0, 0, 0));
		check(slot(1) >> 12, {1'b0, idx});
		check(slot(2), {exp, 4'h0});
		check(last_cmd, {1'b1, idx, 16'h0000});
		$display("test_read done");
	endtask
	// Line is still on-hook here, so slot 5 must carry data.
	task automatic test_rx();
		@(negedge I_MCLK);
		I_RX_A = 16'h8421;
		I_RX_B = 16'h1357;
		I_STATUS = {16'hc03a, 1'b1, 1'b0};
		I_REQ_A = 1'b1;
		// Let the status settle so that the first frame alone reports the change.
		repeat (10) @(negedge I_MCLK);
		xfer(frame(16'h8000, 0, 0, 0, 0, 0));
		check(slot(12) & 20'h00001, 20'h00001);
		xfer(frame(16'h8000, 0, 0, 0, 0, 0));
		check(slot(12) & 20'h00001, 20'h00000);
		check(slot(5), {16'h8421, 4'h0});
		check(slot(10), {16'h1357, 4'h0});
		check({slot(1) & 20'h00213}, 20'h00010);
		check(slot(12) >> 1, {16'hc03a, 1'b0, 1'b1, 1'b0});
		$display("test_rx done");
	endtask
	// Samples are sent only after the request above was seen.
	task automatic test_tx();
		n0 = a_cnt + b_cnt;
		xfer(frame(16'h8428, 0, 0, {16'h5a5a, 4'h0}, {16'ha5c3, 4'h0}, {16'hffff, 4'h0}));
		check(a_cnt + b_cnt - n0, 2);
		check({last_a, last_b}, {16'h5a5a, 16'ha5c3});
		check(O_GPIO_CTRL, 16'hfc3f);
		$display("test_tx done");
	endtask
	task automatic test_pwr();
		for (int i = 0; i < 2; i++) begin
			@(negedge I_MCLK);
			I_RECEIVE_CONVERTER_POWERDOWN = (i == 0);
			I_LINK_HALT_REQUEST = (i == 1);
			xfer(frame(16'h8000, 0, 0, 0, 0, 0));
			xfer(frame(16'h8000, 0, 0, 0, 0, 0));
			check(rx[255:240], 16'he008);
			check({slot(5), slot(10)}, 40'h0);
		end
		@(negedge I_MCLK);
		I_LINK_HALT_REQUEST = 1'b0;
		$display("test_pwr done");
	endtask

	// Hang guard sized well past the fourteen frames the scenarios need.
	initial begin
		#300000;
		error_cnt++;
		summarize();
	end
	initial begin
		{error_cnt, n_tests, cmd_cnt, a_cnt, b_cnt} = '0;
		I_SRST = 1'b1;
		{I_REQ_A, I_REQ_B, I_RECEIVE_CONVERTER_POWERDOWN, I_LINK_HALT_REQUEST} = 4'h0;
		{I_READ_DATA, I_RX_A, I_RX_B} = '0;
		I_STATUS = '0;
		repeat (4) @(posedge I_MCLK);
		@(negedge I_MCLK);
		I_SRST = 1'b0;
		test_ready();
		test_write();
		test_read(7'h20, 16'hbeef);
		test_read(7'h21, 16'h0000);
		test_rx();
		test_tx();
		test_pwr();
		summarize();
	end
endmodule
